// ---- otp_pkg.sv ----
// shared constants for the output test pattern and gain block
`default_nettype none
package otp_pkg;
   // ---------------------------------------------------------------
   // bus and register map (index; byte address is four times it)
   // ---------------------------------------------------------------
   localparam int         AXI_ADDR_W   = 12;
   localparam logic [9:0] CTRL_IDX     = 10'h14A;
   localparam logic [9:0] PAT_LO_IDX   = 10'h14B;
   localparam logic [9:0] PAT_MID_IDX  = 10'h14C;
   localparam logic [9:0] PAT_HI_IDX   = 10'h14D;
   localparam logic [9:0] GAIN_IDX     = 10'h15B;
   localparam logic [9:0] OUTRES_IDX   = 10'h162;
   localparam logic [9:0] STATUS_IDX   = 10'h16F;
   localparam int         CLKSEL_BIT   = 4;
   localparam int         OUTRES_BIT   = 1;
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam logic [7:0] PAT_RST      = 8'h00;
   localparam logic [7:0] GAIN_RST     = 8'h00;
   localparam logic       OUTRES_RST   = 1'h0;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   // ---------------------------------------------------------------
   // pattern codes and widths
   // ---------------------------------------------------------------
   localparam logic [2:0] PAT_OFF         = 3'h0;
   localparam logic [2:0] PAT_RAMP_ONE    = 3'h1;
   localparam logic [2:0] PAT_RAMP_USER   = 3'h2;
   localparam logic [2:0] PAT_STATIC      = 3'h4;
   localparam logic [2:0] PAT_TOGGLE_INV  = 3'h5;
   localparam logic [2:0] PAT_TOGGLE_ZERO = 3'h6;
   localparam int         PAT_W     = 20;
   localparam int         NARROW_W  = 16;
   localparam int         PAD_W     = 12;
   localparam int         OUT_W     = 32;
   localparam int         GAIN_FRAC = 7;

   typedef enum logic [2:0] {
      SEL_NONE, SEL_CTRL, SEL_PAT_LO, SEL_PAT_MID,
      SEL_PAT_HI, SEL_GAIN, SEL_OUTRES, SEL_STATUS
   } reg_sel_t;

   function automatic reg_sel_t reg_decode(input logic [AXI_ADDR_W-1:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      if (a[1:0] != 2'h0) begin
         s = SEL_NONE;
      end else if (a[11:2] == CTRL_IDX) begin
         s = SEL_CTRL;
      end else if (a[11:2] == PAT_LO_IDX) begin
         s = SEL_PAT_LO;
      end else if (a[11:2] == PAT_MID_IDX) begin
         s = SEL_PAT_MID;
      end else if (a[11:2] == PAT_HI_IDX) begin
         s = SEL_PAT_HI;
      end else if (a[11:2] == GAIN_IDX) begin
         s = SEL_GAIN;
      end else if (a[11:2] == OUTRES_IDX) begin
         s = SEL_OUTRES;
      end else if (a[11:2] == STATUS_IDX) begin
         s = SEL_STATUS;
      end
      return s;
   endfunction
endpackage
`default_nettype wire

// ---- pattern_gen.sv ----
// twenty-bit test pattern generator
`timescale 1ns/10ps
`default_nettype none
module pattern_gen
   import otp_pkg::*;
#(
   parameter int W = PAT_W
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         tick,
   input  wire logic [2:0]   mode,
   input  wire logic [W-1:0] user,
   output logic      [W-1:0] word,
   output logic              word_valid
);
   logic phase;

   // ---------------------------------------------------------------
   // generator
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word       <= '0;
         phase      <= 1'b0;
         word_valid <= 1'b0;
      end else begin
         word_valid <= tick && (mode != PAT_OFF);
         if (mode == PAT_OFF) begin
            // ramps restart from zero on the next enable
            word  <= '0;
            phase <= 1'b0;
         end else if (tick) begin
            phase <= ~phase;
            case (mode)
               PAT_RAMP_ONE:    word <= word + W'(1);
               PAT_RAMP_USER:   word <= word + user;
               PAT_STATIC:      word <= user;
               PAT_TOGGLE_INV:  word <= phase ? ~user : user;
               PAT_TOGGLE_ZERO: word <= phase ? '0 : user;
               default:         word <= '0;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_ramp_unit: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && mode == PAT_RAMP_ONE) |=> word == W'($past(word) + W'(1)))
      else $error("ramp did not step by one");
   chk_ramp_user: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && mode == PAT_RAMP_USER) |=> word == W'($past(word) + $past(user)))
      else $error("ramp did not step by user value");
   chk_static_word: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && mode == PAT_STATIC) |=> word == $past(user) && word_valid)
      else $error("static word differs from user value");
   chk_toggle_inv: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && mode == PAT_TOGGLE_INV)
      |=> word == ($past(phase) ? ~$past(user) : $past(user)))
      else $error("inverse toggle did not alternate");
   chk_toggle_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && mode == PAT_TOGGLE_ZERO)
      |=> word == ($past(phase) ? '0 : $past(user)))
      else $error("zero toggle did not alternate");
endmodule
`default_nettype wire

// ---- channel_gain.sv ----
// channel digital gain, 1 + g/128 with saturation
`timescale 1ns/10ps
`default_nettype none
module channel_gain
   import otp_pkg::*;
#(
   parameter int IN_W = 16,
   parameter int G_W  = 8
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   in_valid,
   input  wire logic signed [IN_W-1:0] in_data,
   input  wire logic signed [G_W-1:0]  gain_code,
   output logic                        out_valid,
   output logic signed      [IN_W-1:0] out_data
);
   localparam int SW = IN_W + G_W;
   localparam logic signed [SW-1:0] HI = SW'((2 ** (IN_W - 1)) - 1);
   localparam logic signed [SW-1:0] LO = -SW'(2 ** (IN_W - 1));
   logic signed [SW-1:0] prod;
   logic signed [SW-1:0] sum;

   always_comb begin
      prod = SW'(in_data) * SW'(gain_code);
      sum  = SW'(in_data) + (prod >>> GAIN_FRAC);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            // clip instead of wrapping at full-scale gain
            if (sum > HI) begin
               out_data <= HI[IN_W-1:0];
            end else if (sum < LO) begin
               out_data <= LO[IN_W-1:0];
            end else begin
               out_data <= sum[IN_W-1:0];
            end
         end
      end
   end

   chk_gain_unity: assert property (@(posedge aclk) disable iff (!aresetn)
      (in_valid && gain_code == '0) |=> out_valid && out_data == $past(in_data))
      else $error("zero gain code altered the sample");
endmodule
`default_nettype wire

// ---- output_test_pattern_and_gain.sv ----
// output test pattern and channel gain with axi4-lite registers
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module output_test_pattern_and_gain
   import otp_pkg::*;
#(
   parameter int SAMPLE_W = 16
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [AXI_ADDR_W-1:0] awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [AXI_ADDR_W-1:0] araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   input  wire logic                  sample_tick,
   input  wire logic [SAMPLE_W-1:0]   sample_data,
   input  wire logic                  dec_tick,
   output logic [OUT_W-1:0]           out_word,
   output logic                       out_valid,
   output logic                       pattern_active
);
   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [2:0]            pattern_select;
   logic                  pattern_clk_sel;
   logic [7:0]            pat_lo;
   logic [7:0]            pat_mid;
   logic [3:0]            pat_hi;
   logic [7:0]            channel_gain_code;
   logic                  output_width_select;
   logic [PAT_W-1:0]      user_pattern_value;

   // ---------------------------------------------------------------
   // bus holding state
   // ---------------------------------------------------------------
   logic [AXI_ADDR_W-1:0] aw_addr;
   logic                  aw_held;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;
   logic                  w_held;
   logic                  do_write;
   reg_sel_t              wr_sel;
   reg_sel_t              rd_sel;
   logic [31:0]           rd_value;

   // ---------------------------------------------------------------
   // datapath nets
   // ---------------------------------------------------------------
   logic                  gen_tick;
   logic [PAT_W-1:0]      pat_word;
   logic                  pat_valid;
   logic [SAMPLE_W-1:0]   gain_data;
   logic                  gain_valid;

   assign user_pattern_value = {pat_hi, pat_mid, pat_lo};

   // ---------------------------------------------------------------
   // write channel
   // ---------------------------------------------------------------
   // address and data may arrive in either order; the write lands
   // on the edge that raises bvalid
   always_comb begin
      wr_sel   = reg_decode(aw_addr);
      do_write = aw_held && w_held && !bvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_addr <= awaddr;
            aw_held <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data <= wdata;
            w_strb <= wstrb;
            w_held <= 1'b1;
            wready <= 1'b0;
         end
         if (do_write) begin
            bvalid  <= 1'b1;
            bresp   <= (wr_sel == SEL_NONE || wr_sel == SEL_STATUS) ?
                       RESP_SLVERR : RESP_OKAY;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   // only byte lane zero carries register data; other lanes ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pattern_select      <= CTRL_RST[2:0];
         pattern_clk_sel     <= CTRL_RST[CLKSEL_BIT];
         pat_lo              <= PAT_RST;
         pat_mid             <= PAT_RST;
         pat_hi              <= PAT_RST[3:0];
         channel_gain_code   <= GAIN_RST;
         output_width_select <= OUTRES_RST;
      end else if (do_write && w_strb[0]) begin
         case (wr_sel)
            SEL_CTRL: begin
               // reserved bits are dropped, so they read back as zero
               pattern_select  <= w_data[2:0];
               pattern_clk_sel <= w_data[CLKSEL_BIT];
            end
            SEL_PAT_LO:  pat_lo              <= w_data[7:0];
            SEL_PAT_MID: pat_mid             <= w_data[7:0];
            SEL_PAT_HI:  pat_hi              <= w_data[3:0];
            SEL_GAIN:    channel_gain_code   <= w_data[7:0];
            SEL_OUTRES:  output_width_select <= w_data[OUTRES_BIT];
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   always_comb begin
      rd_sel   = reg_decode(araddr);
      rd_value = 32'h00000000;
      case (rd_sel)
         SEL_CTRL: begin
            rd_value[2:0]        = pattern_select;
            rd_value[CLKSEL_BIT] = pattern_clk_sel;
         end
         SEL_PAT_LO:  rd_value[7:0] = pat_lo;
         SEL_PAT_MID: rd_value[7:0] = pat_mid;
         SEL_PAT_HI:  rd_value[3:0] = pat_hi;
         SEL_GAIN:    rd_value[7:0] = channel_gain_code;
         SEL_OUTRES:  rd_value[OUTRES_BIT] = output_width_select;
         SEL_STATUS: begin
            rd_value[PAT_W-1:0] = pat_word;
            rd_value[PAT_W]     = pattern_active;
         end
         default: rd_value = 32'h00000000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_value;
            rresp   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // generator and gain
   // ---------------------------------------------------------------
   // both tick inputs are same-clock enables, so no synchroniser
   assign gen_tick = pattern_clk_sel ? dec_tick : sample_tick;

   pattern_gen #(
      .W          (PAT_W)
   ) u_pattern_gen (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick       (gen_tick),
      .mode       (pattern_select),
      .user       (user_pattern_value),
      .word       (pat_word),
      .word_valid (pat_valid)
   );

   channel_gain #(
      .IN_W      (SAMPLE_W),
      .G_W       (8)
   ) u_channel_gain (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (sample_tick),
      .in_data   (sample_data),
      .gain_code (channel_gain_code),
      .out_valid (gain_valid),
      .out_data  (gain_data)
   );

   // ---------------------------------------------------------------
   // output formatter
   // ---------------------------------------------------------------
   // pattern and sample paths both carry one register stage, so the
   // switch between them needs no realignment
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_word       <= '0;
         out_valid      <= 1'b0;
         pattern_active <= 1'b0;
      end else begin
         pattern_active <= (pattern_select != PAT_OFF);
         out_valid      <= 1'b0;
         if (pat_valid) begin
            out_valid <= 1'b1;
            if (output_width_select) begin
               out_word <= {pat_word, PAD_W'(0)};
            end else begin
               out_word <= OUT_W'(pat_word[PAT_W-1 -: NARROW_W]);
            end
         end else if (pattern_select == PAT_OFF && gain_valid) begin
            out_valid <= 1'b1;
            if (output_width_select) begin
               out_word <= {gain_data, (OUT_W - SAMPLE_W)'(0)};
            end else begin
               out_word <= OUT_W'(gain_data);
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_off_passes: assert property (@(posedge aclk) disable iff (!aresetn)
      (gain_valid && pattern_select == PAT_OFF && !pat_valid
       && !output_width_select)
      |=> out_valid && out_word == OUT_W'($past(gain_data)))
      else $error("samples not passed with generator off");
   chk_pattern_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
      (pattern_select != PAT_OFF && !pat_valid) |=> !out_valid)
      else $error("sample leaked while pattern active");
   chk_narrow_trunc: assert property (@(posedge aclk) disable iff (!aresetn)
      (pat_valid && !output_width_select)
      |=> out_word == OUT_W'($past(pat_word[PAT_W-1 -: NARROW_W])))
      else $error("narrow output not the top sixteen bits");
   chk_wide_pad: assert property (@(posedge aclk) disable iff (!aresetn)
      (pat_valid && output_width_select)
      |=> out_word[PAD_W-1:0] == '0 && out_word[OUT_W-1:PAD_W] == $past(pat_word))
      else $error("wide output not zero padded");
   chk_clock_select: assert property (@(posedge aclk) disable iff (!aresetn)
      (pattern_select != PAT_OFF && (pattern_clk_sel ? dec_tick : sample_tick))
      |=> pat_valid ##1 out_valid)
      else $error("generator ignored the selected tick");
   chk_high_nibble: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && reg_decode(araddr) == SEL_PAT_HI)
      |=> rvalid && rdata[31:4] == '0)
      else $error("upper bits of pattern high byte not zero");
   chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      (awvalid && awready && wvalid && wready) |-> ##2 bvalid)
      else $error("write response late");

   // ---------------------------------------------------------------
   // bus answer, formatter, reset and generator tick checks
   // ---------------------------------------------------------------
   // reset check runs without disable so that it sees the reset edge
   // tick checks catch a generator stepping on the unselected rate
   chk_read_take: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready) |=> rvalid && !arready)
      else $error("read not answered after address taken");
   chk_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && reg_decode(araddr) == SEL_STATUS)
      |=> rvalid && rdata[PAT_W] == $past(pattern_active))
      else $error("status read lost the active flag");
   chk_write_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && wr_sel == SEL_STATUS) |=> bvalid && bresp == RESP_SLVERR)
      else $error("status write not refused");
   chk_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready && reg_decode(araddr) == SEL_NONE)
      |=> rresp == RESP_SLVERR && rdata == '0)
      else $error("unmapped read not refused");
   chk_reset_off: assert property (@(posedge aclk)
      !aresetn |=> pattern_select == PAT_OFF && !out_valid && !pattern_active)
      else $error("generator not off after reset");
   chk_off_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      (pattern_select == PAT_OFF && !pat_valid && !gain_valid) |=> !out_valid)
      else $error("word emitted with nothing to send");
   chk_wide_sample: assert property (@(posedge aclk) disable iff (!aresetn)
      (gain_valid && pattern_select == PAT_OFF && !pat_valid && output_width_select)
      |=> out_valid && out_word == {$past(gain_data), (OUT_W - SAMPLE_W)'(0)})
      else $error("wide sample not left aligned");
   chk_dec_only: assert property (@(posedge aclk) disable iff (!aresetn)
      (pattern_select != PAT_OFF && pattern_clk_sel && !dec_tick) |=> !pat_valid)
      else $error("generator stepped without decimation tick");
   chk_sample_only: assert property (@(posedge aclk) disable iff (!aresetn)
      (pattern_select != PAT_OFF && !pattern_clk_sel && !sample_tick) |=> !pat_valid)
      else $error("generator stepped without sample tick");
endmodule
`default_nettype wire

// ---- lane_receiver.sv ----
// receiver model that captures words from the output sample lanes
`timescale 1ns/10ps
`default_nettype none
module lane_receiver
   import otp_pkg::*;
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [OUT_W-1:0] out_word,
   input  wire logic             out_valid,
   output logic      [OUT_W-1:0] cap_word,
   output logic                  cap_strobe
);
   // ---------------------------------------------------------------
   // capture
   // ---------------------------------------------------------------
   // latch only on the strobe: the word between strobes is not trusted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_strobe <= 1'b0;
         cap_word   <= '0;
      end else begin
         cap_strobe <= out_valid;
         if (out_valid) begin
            cap_word <= out_word;
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the output test pattern and gain block
`timescale 1ns/10ps
`default_nettype none
module testbench
   import otp_pkg::*;
;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic                  aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0;
   logic                  bready = 0, arvalid = 0, rready = 0;
   logic                  sample_tick = 0, dec_tick = 0;
   logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0]           wdata = '0, rdata;
   logic [3:0]            wstrb = 4'hF;
   logic [1:0]            bresp, rresp;
   logic                  awready, wready, arready, bvalid, rvalid;
   logic                  out_valid, pattern_active, cap_strobe;
   logic [15:0]           sample_data = '0;
   logic [OUT_W-1:0]      out_word, cap_word;
   logic [31:0]           exp_q[$];
   logic [19:0]           user;
   logic [2:0]            modes [5] = '{PAT_RAMP_ONE, PAT_RAMP_USER, PAT_STATIC,
                                        PAT_TOGGLE_INV, PAT_TOGGLE_ZERO};
   int                    failures = 0, comparisons = 0, seed = 43228;

   always #12.5 aclk = ~aclk;

   output_test_pattern_and_gain u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .sample_tick, .sample_data, .dec_tick, .out_word, .out_valid,
      .pattern_active);
   lane_receiver u_rx (.aclk, .aresetn, .out_word, .out_valid, .cap_word, .cap_strobe);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic stop_test;
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // first edge is skipped so no strobe is lowered and raised in one step
   task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
      bit done = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bready && bvalid) begin
            bready <= 0;
            chk({30'h0, bresp}, {30'h0, er});
            done = 1;
         end
      end
   endtask

   task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
      bit done = 0;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1;
      rready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rready && rvalid) begin
            rready <= 0;
            chk(rdata, ed);
            chk({30'h0, rresp}, {30'h0, er});
            done = 1;
         end
      end
   endtask

   task automatic drive(input bit dec, input logic [15:0] s, input bit push,
                        input logic [31:0] e);
      @(posedge aclk);
      sample_data <= s;
      dec_tick <= dec;
      sample_tick <= !dec;
      if (push) exp_q.push_back(e);
      @(posedge aclk);
      dec_tick <= 0;
      sample_tick <= 0;
   endtask

   // even samples keep g = 64 and g = -128 exact, no rounding to guess
   task automatic samp(input int g, input bit wide);
      int s;
      logic [15:0] v;
      s = ($random(seed) % 4000) * 2;
      v = 16'(s + s * g / 128);
      drive(0, 16'(s), 1, wide ? {v, 16'h0} : {16'h0, v});
   endtask

   function automatic logic [31:0] fmt(input logic [19:0] p, input bit wide);
      return wide ? {p, 12'h000} : {16'h0, p[19:4]};
   endfunction

   function automatic logic [19:0] pat(input logic [2:0] m, input int k);
      case (m)
         PAT_RAMP_ONE:   return 20'(k);
         PAT_RAMP_USER:  return 20'(k * user);
         PAT_STATIC:     return user;
         PAT_TOGGLE_INV: return k[0] ? user : ~user;
         default:        return k[0] ? user : 20'h0;
      endcase
   endfunction

   task automatic run(input logic [2:0] m, input bit wide, input bit dc);
      wr(OUTRES_IDX, {6'h0, wide, 1'b0}, RESP_OKAY);
      wr(CTRL_IDX, {3'h0, dc, 1'b0, m}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({31'h0, pattern_active}, 1);
      for (int k = 1; k <= 5; k++) begin
         drive(dc, 16'($random(seed)), 1, fmt(pat(m, k), wide));
         if (dc) drive(0, 16'($random(seed)), 0, 0);
      end
      rd(STATUS_IDX, {11'h0, 1'b1, pat(m, 5)}, RESP_OKAY);
      wr(CTRL_IDX, 8'h00, RESP_OKAY);
      samp(0, wide);
      chk({31'h0, pattern_active}, 0);
   endtask

   // ---------------------------------------------------------------
   // monitor, watchdog and main sequence
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      if (cap_strobe === 1'b1) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("CHECK FAILED %0t: unexpected word %h", $time, cap_word);
         end else begin
            chk(cap_word, exp_q.pop_front());
         end
      end
   end

   initial begin
      #(25 * 20000);
      failures++;
      $display("CHECK FAILED %0t: timeout", $time);
      stop_test;
   end

   initial begin
      user = 20'($random(seed));
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      rd(CTRL_IDX, 0, RESP_OKAY);
      rd(10'h000, 0, RESP_SLVERR);
      wr(STATUS_IDX, 8'h00, RESP_SLVERR);
      samp(0, 0);
      wr(GAIN_IDX, 8'h80, RESP_OKAY);
      samp(-128, 0);
      wr(GAIN_IDX, 8'h40, RESP_OKAY);
      wr(OUTRES_IDX, 8'h02, RESP_OKAY);
      samp(64, 1);
      wr(GAIN_IDX, 8'h00, RESP_OKAY);
      wr(PAT_LO_IDX, user[7:0], RESP_OKAY);
      wr(PAT_MID_IDX, user[15:8], RESP_OKAY);
      wr(PAT_HI_IDX, {4'hA, user[19:16]}, RESP_OKAY);
      rd(PAT_HI_IDX, {28'h0, user[19:16]}, RESP_OKAY);
      // only defined codes are written, never 011 or 111
      for (int i = 0; i < 10; i++) run(modes[i % 5], i / 5, 0);
      run(PAT_RAMP_ONE, 0, 1);
      repeat (6) @(posedge aclk);
      chk(exp_q.size(), 0);
      stop_test;
   end
endmodule
`default_nettype wire
